// >>> bench/ssfcp_master.sv
// Purpose: behavioural spi master facing the slave port
// Assumes: link clock period 400 ns, idle sck level follows cpol
// Notes:   mosi flips after each byte so stale bits never look valid

`timescale 1ns/100ps

module ssfcp_master
  import ssfcp_pkg::*;
(
  input  logic cpol,
  input  logic cpha,
  input  logic lsb_first,
  input  logic spi_miso,
  input  logic spi_rdy,
  output logic spi_sck,
  output logic spi_csn,
  output logic spi_mosi
);
  localparam int HALF_NS = 200;
  int   tmo;
  logic rdy_early;

  initial begin
    spi_sck   = 1'b0;
    spi_csn   = 1'b1;
    spi_mosi  = 1'b0;
    tmo       = 0;
    rdy_early = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // link tasks
  // ---------------------------------------------------------------------------
  task automatic wait_rdy();
    int n;
    n = 0;
    while (spi_rdy !== 1'b1 && n < 4000) begin
      #50;
      n++;
    end
    if (n >= 4000) tmo++;
  endtask

  task automatic sel(input logic low);
    if (low) begin
      spi_sck = cpol;
      #HALF_NS;
      spi_csn = 1'b0;
      // probe only; the start decision waits past 100 ns
      #250;
      rdy_early = spi_rdy;
    end else begin
      spi_csn = 1'b1;
      #HALF_NS;
    end
  endtask

  task automatic xbyte(input logic [7:0] tx, input logic pace,
                       output logic [7:0] rx);
    int b;
    if (pace) wait_rdy();
    for (int i = 0; i < 8; i++) begin
      b = lsb_first ? i : 7 - i;
      if (!cpha) spi_mosi = tx[b];
      #HALF_NS;
      spi_sck = ~cpol;
      if (cpha) spi_mosi = tx[b];
      else rx[b] = spi_miso;
      #HALF_NS;
      spi_sck = cpol;
      if (cpha) rx[b] = spi_miso;
    end
    // flip only after the last trailing edge has been taken
    #HALF_NS;
    spi_mosi = ~spi_mosi;
    // ready lags the last edge, so never look at it too soon
    #HALF_NS;
  endtask

  task automatic hdr(input logic [7:0] ctrl, output logic [7:0] s1,
                     output logic [7:0] s2);
    xbyte(ctrl, 1'b1, s1);
    xbyte(HDR_DUMMY, 1'b0, s2);
  endtask
endmodule

// >>> bench/ssfcp_port_tb.sv
// Purpose: self-checking bench of the flow-controlled spi slave port
// Assumes: 20 MHz clk, master model paces on ready or on the room byte
// Notes:   mode cases live in a row table; corner cases follow it

`timescale 1ns/100ps

module ssfcp_port_tb;
  import ssfcp_pkg::*;

  typedef struct packed {
    logic       cpol;
    logic       cpha;
    logic       lsb;
    logic [7:0] dat;
    logic [7:0] rd_room;
    logic [7:0] wr_room;
  } ssfcp_row_s;

  logic              clk = 1'b0;
  logic              srst;
  logic              port_en;
  logic              flow_en;
  logic              cpol;
  logic              cpha;
  logic              lsb_first;
  logic              spi_sck;
  logic              spi_csn;
  logic              spi_mosi;
  logic              spi_miso;
  logic              spi_miso_oe_n;
  logic              miso_pin;
  logic              spi_rdy;
  logic [BYTE_W-1:0] rx_data;
  logic              rx_valid;
  logic              rx_ready;
  logic [BYTE_W-1:0] tx_data;
  logic              tx_valid;
  logic              tx_ready;
  logic [CNT_W-1:0]  rx_level;
  logic [CNT_W-1:0]  tx_level;
  logic              xfer_active;
  int                num_errors;
  int                checked;
  ssfcp_row_s        rows [4];
  logic [7:0]        s1;
  logic [7:0]        s2;
  logic [7:0]        d;

  always #25 clk = ~clk;

  // released miso reads as the inverse of spi_miso, a held high while deselected
  assign miso_pin = spi_miso_oe_n ? ~spi_miso : spi_miso;

  ssfcp_port i_ssfcp_port (
    .clk           (clk),
    .srst          (srst),
    .port_en       (port_en),
    .flow_en       (flow_en),
    .cpol          (cpol),
    .cpha          (cpha),
    .lsb_first     (lsb_first),
    .spi_sck       (spi_sck),
    .spi_csn       (spi_csn),
    .spi_mosi      (spi_mosi),
    .spi_miso      (spi_miso),
    .spi_miso_oe_n (spi_miso_oe_n),
    .spi_rdy       (spi_rdy),
    .rx_data       (rx_data),
    .rx_valid      (rx_valid),
    .rx_ready      (rx_ready),
    .tx_data       (tx_data),
    .tx_valid      (tx_valid),
    .tx_ready      (tx_ready),
    .rx_level      (rx_level),
    .tx_level      (tx_level),
    .xfer_active   (xfer_active)
  );

  ssfcp_master i_ssfcp_master (
    .cpol      (cpol),
    .cpha      (cpha),
    .lsb_first (lsb_first),
    .spi_miso  (miso_pin),
    .spi_rdy   (spi_rdy),
    .spi_sck   (spi_sck),
    .spi_csn   (spi_csn),
    .spi_mosi  (spi_mosi)
  );

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk_byte(input string nm, input logic [7:0] exp,
                          input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic results();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic push(input logic [7:0] b);
    @(negedge clk);
    tx_data  = b;
    tx_valid = 1'b1;
    @(negedge clk);
    tx_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic pop_chk(input logic [7:0] exp);
    @(negedge clk);
    chk_bit("rx_valid", 1'b1, rx_valid);
    chk_byte("rx_data", exp, rx_data);
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    @(negedge clk);
  endtask

  task automatic open(input logic [7:0] ctrl);
    i_ssfcp_master.sel(1'b1);
    i_ssfcp_master.hdr(ctrl, s1, s2);
    chk_byte("device_status_byte", STATUS_READY, s1);
  endtask

  task automatic close();
    i_ssfcp_master.sel(1'b0);
    repeat (4) @(negedge clk);
    chk_bit("xfer_active", 1'b0, xfer_active);
  endtask

  // ---------------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------------
  initial begin
    srst       = 1'b1;
    port_en    = 1'b1;
    flow_en    = 1'b1;
    cpol       = 1'b0;
    cpha       = 1'b0;
    lsb_first  = 1'b0;
    rx_ready   = 1'b0;
    tx_valid   = 1'b0;
    tx_data    = 8'h00;
    num_errors = 0;
    checked    = 0;
    rows[0] = '{1'b0, 1'b0, 1'b0, 8'h1e, 8'h01, 8'(FIFO_DEPTH)};
    rows[1] = '{1'b0, 1'b1, 1'b1, 8'hc4, 8'h01, 8'(FIFO_DEPTH)};
    rows[2] = '{1'b1, 1'b0, 1'b1, 8'h35, 8'h01, 8'(FIFO_DEPTH)};
    rows[3] = '{1'b1, 1'b1, 1'b0, 8'h6a, 8'h01, 8'(FIFO_DEPTH)};
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk_bit("rdy_reset", 1'b0, spi_rdy);
    chk_bit("oe_n_reset", 1'b1, spi_miso_oe_n);
    chk_bit("tx_ready", 1'b1, tx_ready);
    chk_byte("rx_level", 8'h00, 8'(rx_level));
    foreach (rows[k]) begin
      @(negedge clk);
      cpol      = rows[k].cpol;
      cpha      = rows[k].cpha;
      lsb_first = rows[k].lsb;
      push(rows[k].dat);
      chk_bit("idle_rdy", 1'b1, spi_rdy);
      i_ssfcp_master.sel(1'b1);
      chk_bit("rdy_select", 1'b0, i_ssfcp_master.rdy_early);
      i_ssfcp_master.hdr(CTRL_READ, s1, s2);
      chk_byte("device_status_byte", STATUS_READY, s1);
      chk_byte("room_rd", rows[k].rd_room, s2);
      i_ssfcp_master.xbyte(8'h00, 1'b1, d);
      chk_byte("rd_data", rows[k].dat, d);
      close();
      chk_bit("empty_rdy", 1'b0, spi_rdy);
      open(CTRL_WRITE);
      chk_byte("room_wr", rows[k].wr_room, s2);
      i_ssfcp_master.xbyte(~rows[k].dat, 1'b1, d);
      close();
      pop_chk(~rows[k].dat);
    end
    @(negedge clk);
    cpol      = 1'b0;
    cpha      = 1'b0;
    lsb_first = 1'b0;
    push(8'h11);
    push(8'h22);
    push(8'h33);
    open(CTRL_READ);
    chk_byte("room_rd", 8'h03, s2);
    close();
    chk_byte("tx_level", 8'h03, 8'(tx_level));
    open(CTRL_READ);
    for (int j = 0; j < s2; j++) begin
      i_ssfcp_master.xbyte(8'h00, 1'b0, d);
      chk_byte("burst", 8'(8'h11 * (j + 1)), d);
    end
    close();
    chk_byte("tx_level", 8'h00, 8'(tx_level));
    open(8'h5a);
    chk_byte("room_skip", FILL_BYTE, s2);
    i_ssfcp_master.xbyte(8'h3c, 1'b1, d);
    chk_byte("skip_data", FILL_BYTE, d);
    close();
    chk_byte("skip_rx", 8'h00, 8'(rx_level));
    open(CTRL_WRITE);
    for (int j = 0; j < FIFO_DEPTH; j++) i_ssfcp_master.xbyte(8'(j), 1'b1, d);
    chk_byte("rx_full", 8'(FIFO_DEPTH), 8'(rx_level));
    chk_bit("full_rdy", 1'b0, spi_rdy);
    i_ssfcp_master.xbyte(8'hee, 1'b0, d);
    close();
    chk_byte("rx_kept", 8'(FIFO_DEPTH), 8'(rx_level));
    open(CTRL_WRITE);
    chk_byte("room_full", 8'h00, s2);
    close();
    for (int j = 0; j < FIFO_DEPTH; j++) pop_chk(8'(j));
    chk_bit("rx_drained", 1'b0, rx_valid);
    @(negedge clk);
    flow_en = 1'b0;
    repeat (4) @(negedge clk);
    chk_bit("noflow_idle", 1'b1, spi_rdy);
    open(CTRL_WRITE);
    chk_bit("noflow_xfer", 1'b1, spi_rdy);
    close();
    flow_en = 1'b1;
    port_en = 1'b0;
    push(8'h5a);
    chk_bit("off_rdy", 1'b0, spi_rdy);
    i_ssfcp_master.sel(1'b1);
    chk_bit("off_oe_n", 1'b1, spi_miso_oe_n);
    chk_bit("off_active", 1'b0, xfer_active);
    i_ssfcp_master.sel(1'b0);
    port_en = 1'b1;
    repeat (4) @(negedge clk);
    chk_bit("on_rdy", 1'b1, spi_rdy);
    chk_byte("master_waits", 8'h00, 8'(i_ssfcp_master.tmo));
    results();
  end

  // whole sequence needs well under 1 ms of link traffic
  initial begin
    #3000000;
    num_errors++;
    results();
  end
endmodule

// >>> design/ssfcp_fifo.sv
// Purpose: byte fifo in flip-flops with registered level and flags
// Assumes: depth is a power of two
// Notes:   push when full and pop when empty are ignored

`timescale 1ns/100ps

module ssfcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
)(
  input  logic             clk,
  input  logic             srst,
  input  logic             push,
  input  logic [WIDTH-1:0] push_data,
  input  logic             pop,
  output logic [WIDTH-1:0] head,
  output logic [AW:0]      count,
  output logic             full,
  output logic             empty
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push_ok;
  logic             pop_ok;
  logic [AW:0]      next_count;

  assign push_ok = push & ~full;
  assign pop_ok  = pop & ~empty;
  assign head    = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push_ok && !pop_ok) begin
      next_count = count + 1'b1;
    end else if (pop_ok && !push_ok) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push_ok) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop_ok) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
      full  <= 1'b0;
      empty <= 1'b1;
    end else begin
      count <= next_count;
      full  <= (next_count == (AW+1)'(DEPTH));
      empty <= (next_count == '0);
    end
  end

endmodule

// >>> design/ssfcp_pkg.sv
// Purpose: shared constants and types of the flow-controlled spi slave port
// Assumes: 20 MHz system clock, byte-wide serial frames
// Notes:   every number of the port is named once here

package ssfcp_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  // ready is held low this long after chip select falls
  localparam int HDR_PREP_NS   = 100;
  localparam int HDR_PREP_CYC  = (HDR_PREP_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [1:0] HDR_PREP_CNT = 2'(HDR_PREP_CYC);

  // ---------------------------------------------------------------------------
  // buffers
  // ---------------------------------------------------------------------------
  localparam int FIFO_DEPTH = 64;
  localparam int BYTE_W     = 8;
  localparam int CNT_W      = $clog2(FIFO_DEPTH) + 1;

  // ---------------------------------------------------------------------------
  // header codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_READ    = 8'h81;
  localparam logic [7:0] CTRL_WRITE   = 8'h42;
  localparam logic [7:0] HDR_DUMMY    = 8'h00;
  localparam logic [7:0] STATUS_READY = 8'hc0;
  localparam logic [7:0] FILL_BYTE    = 8'h00;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [2:0] FIRST_BIT    = 3'h0;

  // ---------------------------------------------------------------------------
  // transaction states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_CTRL    = 3'b001,
    ST_STAT_RD = 3'b010,
    ST_STAT_WR = 3'b011,
    ST_READ    = 3'b100,
    ST_WRITE   = 3'b101,
    ST_SKIP    = 3'b110
  } ssfcp_state_e;

endpackage

// >>> design/ssfcp_port.sv
// Purpose: spi slave transport port with ready-line and count flow control
// Assumes: spi pins are asynchronous and oversampled by clk
// Notes:   mode and bit order must stay stable while chip select is low

`timescale 1ns/100ps

module ssfcp_port
  import ssfcp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  input  logic              clk,
  input  logic              srst,
  input  logic              port_en,
  input  logic              flow_en,
  input  logic              cpol,
  input  logic              cpha,
  input  logic              lsb_first,
  input  logic              spi_sck,
  input  logic              spi_csn,
  input  logic              spi_mosi,
  output logic              spi_miso,
  output logic              spi_miso_oe_n,
  output logic              spi_rdy,
  output logic [BYTE_W-1:0] rx_data,
  output logic              rx_valid,
  input  logic              rx_ready,
  input  logic [BYTE_W-1:0] tx_data,
  input  logic              tx_valid,
  output logic              tx_ready,
  output logic [CNT_W-1:0]  rx_level,
  output logic [CNT_W-1:0]  tx_level,
  output logic              xfer_active
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic [2:0]        sync1;
  logic [2:0]        sync2;
  logic [2:0]        sync3;
  logic              sck_lvl;
  logic              cs_act;
  ssfcp_state_e      state;
  logic [2:0]        bit_cnt;
  logic [2:0]        out_idx;
  logic [7:0]        in_sr;
  logic [7:0]        out_byte;
  logic              reload;
  logic              sent_valid;
  logic [1:0]        wait_cnt;

  logic              sck_edge;
  logic              sck_rise;
  logic              sck_fall;
  logic              csn_lo;
  logic              csn_hi;
  logic              cs_start;
  logic              cs_end;
  logic              lead;
  logic              trail;
  logic              samp;
  logic              shft;
  logic [7:0]        next_in;
  logic              byte_done;
  logic              rx_push;
  logic              tx_pop;
  logic              rx_full;
  logic              rx_empty;
  logic              tx_full;
  logic              tx_empty;
  logic [7:0]        tx_head;
  logic [CNT_W-1:0]  rx_count;
  logic [CNT_W-1:0]  tx_count;
  logic [CNT_W-1:0]  rx_room;
  logic [2:0]        bsel;
  logic [2:0]        next_idx;
  logic              top_up;
  logic              next_rdy;
  logic [7:0]        next_out;

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1 <= 3'h2;
      sync2 <= 3'h2;
      sync3 <= 3'h2;
    end else begin
      sync1 <= {spi_mosi, spi_csn, spi_sck};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // an sck change counts only once stages two and three agree
  assign sck_edge = (sync2[0] == sync3[0]) && (sync3[0] != sck_lvl);
  assign sck_rise = sck_edge & sync3[0];
  assign sck_fall = sck_edge & ~sync3[0];
  assign csn_lo   = ~sync2[1] & ~sync3[1];
  assign csn_hi   = sync2[1] & sync3[1];

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_lvl <= 1'b0;
    end else if (sync2[0] == sync3[0]) begin
      sck_lvl <= sync3[0];
    end
  end

  // ---------------------------------------------------------------------------
  // framing and clock mode
  // ---------------------------------------------------------------------------
  assign cs_start = port_en & ~cs_act & csn_lo;
  assign cs_end   = cs_act & (csn_hi | ~port_en);
  assign lead     = cpol ? sck_fall : sck_rise;
  assign trail    = cpol ? sck_rise : sck_fall;
  assign samp     = cs_act & ~cs_end & (cpha ? trail : lead);
  assign shft     = cs_act & ~cs_end & (cpha ? lead : trail);
  assign next_in  = lsb_first ? {sync3[2], in_sr[7:1]}
                              : {in_sr[6:0], sync3[2]};
  assign byte_done = samp & (bit_cnt == LAST_BIT);
  // write data only, and never past full, so an abort loses nothing
  assign rx_push  = byte_done & (state == ST_WRITE) & ~rx_full;
  // a byte leaves the tx fifo only once fully shifted out
  assign tx_pop   = byte_done & (state == ST_READ) & sent_valid;
  assign rx_room  = CNT_W'(DEPTH) - rx_count;
  // look one shift ahead: sync lag leaves no cycle spare in a half period
  assign next_idx = shft ? (out_idx + 3'h1) : out_idx;
  assign bsel     = lsb_first ? next_idx : (LAST_BIT - next_idx);
  // refresh an empty read byte when data arrives while the master waits
  assign top_up   = (state == ST_READ) & ~sent_valid & ~tx_empty
                    & (bit_cnt == FIRST_BIT) & ~reload & ~byte_done;

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_act <= 1'b0;
    end else if (cs_start) begin
      cs_act <= 1'b1;
    end else if (cs_end) begin
      cs_act <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // transaction state
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else if (cs_end) begin
      state <= ST_IDLE;
    end else if (cs_start) begin
      state <= ST_CTRL;
    end else if (byte_done) begin
      unique case (state)
        ST_CTRL: begin
          if (next_in == CTRL_READ) begin
            state <= ST_STAT_RD;
          end else if (next_in == CTRL_WRITE) begin
            state <= ST_STAT_WR;
          end else begin
            state <= ST_SKIP;
          end
        end
        // second header byte is the dummy, its content is not checked
        ST_STAT_RD: state <= ST_READ;
        ST_STAT_WR: state <= ST_WRITE;
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_SKIP:    state <= state;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bit_cnt <= FIRST_BIT;
      in_sr   <= 8'h00;
    end else if (cs_start) begin
      bit_cnt <= FIRST_BIT;
    end else if (samp) begin
      bit_cnt <= bit_cnt + 3'h1;
      in_sr   <= next_in;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wait_cnt <= 2'h0;
    end else if (cs_start) begin
      wait_cnt <= 2'h0;
    end else if (state == ST_CTRL && wait_cnt != HDR_PREP_CNT) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // outgoing byte
  // ---------------------------------------------------------------------------
  always_comb begin
    next_out = FILL_BYTE;
    unique case (state)
      ST_STAT_RD: next_out = 8'(tx_count);
      ST_STAT_WR: next_out = 8'(rx_room);
      ST_READ:    next_out = tx_empty ? FILL_BYTE : tx_head;
      ST_IDLE,
      ST_CTRL,
      ST_WRITE,
      ST_SKIP:    next_out = FILL_BYTE;
    endcase
  end

  // reload waits one cycle so the fifo head has moved after a pop
  always_ff @(posedge clk) begin
    if (srst) begin
      reload <= 1'b0;
    end else begin
      reload <= byte_done & ~cs_end;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_byte   <= 8'h00;
      out_idx    <= FIRST_BIT;
      sent_valid <= 1'b0;
    end else if (cs_start) begin
      out_byte   <= STATUS_READY;
      out_idx    <= cpha ? LAST_BIT : FIRST_BIT;
      sent_valid <= 1'b0;
    end else if (cs_end) begin
      sent_valid <= 1'b0;
    end else begin
      if (reload || top_up) begin
        out_byte   <= next_out;
        sent_valid <= (state == ST_READ) & ~tx_empty;
      end
      if (shft) begin
        out_idx <= out_idx + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // pins out
  // ---------------------------------------------------------------------------
  always_comb begin
    next_rdy = 1'b0;
    if (!port_en) begin
      next_rdy = 1'b0;
    end else if (!flow_en) begin
      next_rdy = 1'b1;
    end else if (cs_start || cs_end) begin
      next_rdy = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE:    next_rdy = ~tx_empty;
        ST_CTRL:    next_rdy = (wait_cnt == HDR_PREP_CNT);
        ST_STAT_RD,
        ST_STAT_WR,
        ST_SKIP:    next_rdy = 1'b1;
        ST_READ:    next_rdy = sent_valid & ~reload & ~byte_done;
        ST_WRITE:   next_rdy = ~rx_full & ~rx_push;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      spi_rdy       <= 1'b0;
      spi_miso      <= 1'b0;
      spi_miso_oe_n <= 1'b1;
      xfer_active   <= 1'b0;
    end else begin
      spi_rdy       <= next_rdy;
      spi_miso      <= cs_act & out_byte[bsel];
      spi_miso_oe_n <= ~(cs_act & ~cs_end);
      xfer_active   <= cs_act & ~cs_end;
    end
  end

  // ---------------------------------------------------------------------------
  // buffers
  // ---------------------------------------------------------------------------
  ssfcp_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .srst      (srst),
    .push      (rx_push),
    .push_data (next_in),
    .pop       (rx_ready),
    .head      (rx_data),
    .count     (rx_count),
    .full      (rx_full),
    .empty     (rx_empty)
  );

  ssfcp_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .srst      (srst),
    .push      (tx_valid),
    .push_data (tx_data),
    .pop       (tx_pop),
    .head      (tx_head),
    .count     (tx_count),
    .full      (tx_full),
    .empty     (tx_empty)
  );

  assign rx_valid = ~rx_empty;
  assign tx_ready = ~tx_full;
  assign rx_level = rx_count;
  assign tx_level = tx_count;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_rdy_disabled: assert property (
    !port_en ##1 !port_en |-> !spi_rdy && spi_miso_oe_n)
    else $error("ready or miso active while port disabled");

  a_rdy_noflow: assert property (
    port_en && !flow_en ##1 port_en && !flow_en |-> spi_rdy)
    else $error("ready not high with flow control off");

  a_rdy_drop: assert property (
    cs_start && flow_en |=> !spi_rdy ##1 !spi_rdy)
    else $error("ready not held low after select fall");

  a_rdy_hdr: assert property (
    state == ST_CTRL && wait_cnt == HDR_PREP_CNT && port_en && flow_en
      && !cs_end |=> spi_rdy)
    else $error("ready not raised for header");

  a_ctrl_decode: assert property (
    byte_done && state == ST_CTRL && !cs_end |=>
      state == (($past(next_in) == CTRL_READ)  ? ST_STAT_RD :
                ($past(next_in) == CTRL_WRITE) ? ST_STAT_WR : ST_SKIP))
    else $error("control byte decoded wrongly");

  a_status1: assert property (
    cs_start |=> out_byte == STATUS_READY)
    else $error("first status byte wrong");

  a_status2: assert property (
    byte_done && state == ST_CTRL && next_in == CTRL_WRITE && !cs_end
      |=> ##1 out_byte == 8'($past(rx_room))
          || out_byte == 8'(rx_room) || $past(rx_ready))
    else $error("room byte does not match rx space");

  a_idle_rdy: assert property (
    state == ST_IDLE && !cs_act && !cs_start && port_en && flow_en
      |=> spi_rdy != $past(tx_empty))
    else $error("idle ready does not follow tx data");

  a_one_dir: assert property (
    (state == ST_WRITE |=> tx_level >= $past(tx_level))
      and (state == ST_READ |=> rx_level <= $past(rx_level)))
    else $error("both directions moved in one transaction");

  a_abort: assert property (
    cs_end |=> state == ST_IDLE && !reload && !sent_valid)
    else $error("transaction not closed on select rise");

  a_wr_full: assert property (
    state == ST_WRITE && rx_full && port_en && flow_en && !cs_end
      |=> !spi_rdy)
    else $error("ready high with rx fifo full");

  c_read: cover property (byte_done && state == ST_STAT_RD);
  c_write: cover property (rx_push ##[1:200] rx_push);
  c_abort: cover property (state == ST_STAT_WR ##1 cs_end);
  c_mode3: cover property (cpol && cpha && byte_done);

endmodule
